// >>> cts_node.sv
// far-side can node model: drives the rx level seen by the block
// assumes recessive (pull-up) idle between frames
module cts_node (
  input  wire logic clk_i,
  input  wire logic frame_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_q;
  always_ff @(posedge clk_i) begin
    ph_q <= frame_i ? ph_q + 3'h1 : 3'h0;
  end
  // frame toggles every four cycles, never eleven recessive bits
  assign rx_o = frame_i ? ph_q[2] : 1'b1;
endmodule : cts_node

// >>> cts_pkg.sv
// package for the can transmit buffer select, sleep and init block
// assumes a 32-bit apb slave with byte offsets chosen below
package cts_pkg;
  localparam int unsigned NUM_TXBUF       = 3;
  localparam logic [7:0]  ADDR_INIT_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS     = 8'h04;
  localparam logic [7:0]  ADDR_TBSEL      = 8'h08;
  localparam logic [7:0]  ADDR_TFLG       = 8'h0C;
  localparam logic [7:0]  ADDR_TXWIN      = 8'h10;
  localparam logic [7:0]  ADDR_TXSCHED    = 8'h14;
  localparam int unsigned CTRL_INIT_REQUEST_BIT = 0;
  localparam int unsigned CTRL_SLEEP_REQUEST_BIT  = 1;
  localparam int unsigned ST_INIT_ACKNOWLEDGE_BIT   = 0;
  localparam int unsigned ST_SLEEP_ACKNOWLEDGE_BIT    = 1;
  localparam int unsigned ST_SYNC_BIT     = 2;
  localparam int unsigned ST_BUSOFF_BIT   = 3;
  localparam int unsigned ST_BLOCK_BIT    = 4;
  localparam logic [2:0]  TBSEL_RESET     = 3'h0;
  localparam logic [2:0]  TFLG_RESET      = 3'h7;
  localparam int unsigned IDLE_BITS       = 11;
  localparam int unsigned BUSOFF_RUNS     = 128;
  localparam logic [31:0] WIN_RESET       = 32'h0000_0000;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cts_apb_req_t;

  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } cts_apb_rsp_t;

  typedef enum logic [1:0] { CTS_RUN, CTS_INIT, CTS_SLEEP, CTS_WAKE } cts_mode_t;
endpackage : cts_pkg

// >>> cts_top.sv
// can transmit buffer select, sleep/wake and init mode control
// assumes an apb master on clk_sys_i; bus rx pin is asynchronous
// What this block does
// - map lowest selected buffer into window
// - select reads give lowest set bit only
// - init mode holds select at reset
// - select writable only outside init mode
// - block window on scheduled non-empty buffer
// - no window access when none selected
// - ignore sleep request clear before sleep
// - clearing sleep request leaves sleep mode
// - wait 11 recessive bits after wake
// - transmit buffers kept across sleep
// - pending actions run upon wake
// - bus-off recessive run count not restarted
// - init aborts traffic and drops sync
// - init forces transmit pin recessive
//
// Added by the designer: the placing of the registers and the APB register port.
module cts_top
  import cts_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 25
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        bus_rx_i,
  input  wire logic        busoff_i,
  input  wire logic [2:0]  tx_done_i,
  output logic             bus_transmit_pin_o,
  output logic             bus_synced_o,
  output logic             pending_run_o,
  output logic [2:0]       fg_txbuf_o
);
  cts_apb_req_t req;
  cts_apb_rsp_t rsp;
  cts_mode_t    mode_q;
  logic [2:0]   tbsel_q, tflg_q, sched_q, lowest;
  logic [31:0]  win_q [NUM_TXBUF];
  logic         init_rq_q, slp_rq_q, sync_q, pend_q;
  logic         rx_m_q, rx_q;
  logic [3:0]   run_q;
  logic [7:0]   boff_q;
  logic [15:0]  bitc_q;
  logic         init_ak, slp_ak, wr_acc, blocked;
  logic [1:0]   idx;

  assign req = '{sel: psel_i, en: penable_i, wr: pwrite_i, addr: paddr_i,
                 wdata: pwdata_i};
  assign init_ak = (mode_q == CTS_INIT);
  assign slp_ak  = (mode_q == CTS_SLEEP);
  assign wr_acc  = req.sel & req.en & req.wr;

  // lowest set bit of the select register
  always_comb begin
    lowest = 3'h0;
    idx    = 2'd0;
    for (int i = NUM_TXBUF - 1; i >= 0; i--) begin
      if (tbsel_q[i]) begin
        lowest = 3'h0;
        lowest[i] = 1'b1;
        idx = 2'(i);
      end
    end
  end
  assign fg_txbuf_o = lowest;
  assign blocked = (lowest == 3'h0) |
                   (~tflg_q[idx] & sched_q[idx]);

  always_ff @(posedge clk_sys_i) begin
    rx_m_q <= bus_rx_i;
    rx_q   <= rx_m_q;
  end

  // mode sequencing
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mode_q    <= CTS_INIT;
      init_rq_q <= 1'b1;
      slp_rq_q  <= 1'b0;
    end else begin
      if (wr_acc && req.addr == ADDR_INIT_CTRL) begin
        init_rq_q <= req.wdata[CTRL_INIT_REQUEST_BIT];
        if (req.wdata[CTRL_SLEEP_REQUEST_BIT])
          slp_rq_q <= 1'b1;
        else if (slp_ak)
          slp_rq_q <= 1'b0;
      end
      case (mode_q)
        CTS_RUN: begin
          if (init_rq_q) mode_q <= CTS_INIT;
          else if (slp_rq_q) mode_q <= CTS_SLEEP;
        end
        CTS_INIT: if (!init_rq_q) mode_q <= CTS_WAKE;
        CTS_SLEEP: begin
          if (init_rq_q) mode_q <= CTS_INIT;
          else if (!slp_rq_q) mode_q <= CTS_WAKE;
        end
        CTS_WAKE: begin
          if (init_rq_q) mode_q <= CTS_INIT;
          else if (sync_q) mode_q <= CTS_RUN;
        end
        default: mode_q <= CTS_INIT;
      endcase
    end
  end

  // bit timer and recessive run counter
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rx_q || mode_q == CTS_INIT || mode_q == CTS_SLEEP) begin
      bitc_q <= 16'h0000;
      run_q  <= 4'h0;
    end else if (bitc_q == 16'(BIT_CYCLES - 1)) begin
      bitc_q <= 16'h0000;
      if (run_q == 4'(IDLE_BITS - 1)) run_q <= 4'h0;
      else run_q <= run_q + 4'h1;
    end else begin
      bitc_q <= bitc_q + 16'h0001;
    end
  end

  logic run_done;
  assign run_done = rx_q && bitc_q == 16'(BIT_CYCLES - 1) &&
                    run_q == 4'(IDLE_BITS - 1);

  // sync only after a full idle run following wake
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || mode_q == CTS_INIT) sync_q <= 1'b0;
    else if (mode_q == CTS_SLEEP) sync_q <= 1'b0;
    else if (mode_q == CTS_WAKE && run_done) sync_q <= 1'b1;
  end
  assign bus_synced_o = sync_q;

  // bus-off recovery count survives sleep
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !busoff_i) boff_q <= 8'h00;
    else if (run_done && boff_q != 8'(BUSOFF_RUNS)) boff_q <= boff_q + 8'h01;
  end

  // pending actions resume when leaving sleep
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) pend_q <= 1'b0;
    else pend_q <= (mode_q == CTS_SLEEP) && !slp_rq_q;
  end
  assign pending_run_o = pend_q;
  assign bus_transmit_pin_o = 1'b1;

  // select register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || (init_rq_q && init_ak)) tbsel_q <= TBSEL_RESET;
    else if (wr_acc && req.addr == ADDR_TBSEL && !init_rq_q && !init_ak)
      tbsel_q <= req.wdata[2:0];
  end

  // empty flags and schedule; a done pulse beats a new schedule
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || mode_q == CTS_INIT) begin
      tflg_q  <= TFLG_RESET;
      sched_q <= 3'h0;
    end else begin
      if (wr_acc && req.addr == ADDR_TXSCHED && !blocked) begin
        tflg_q  <= (tflg_q & ~lowest) | tx_done_i;
        sched_q <= (sched_q | lowest) & ~tx_done_i;
      end else begin
        tflg_q  <= tflg_q | tx_done_i;
        sched_q <= sched_q & ~tx_done_i;
      end
    end
  end

  // transmit buffers, kept through sleep
  for (genvar g = 0; g < NUM_TXBUF; g++) begin : g_win
    always_ff @(posedge clk_sys_i) begin
      if (srst_i) win_q[g] <= WIN_RESET;
      else if (wr_acc && req.addr == ADDR_TXWIN && !blocked && idx == 2'(g))
        win_q[g] <= req.wdata;
    end
  end

  // apb read and answer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rsp <= '0;
    end else begin
      rsp.ready  <= req.sel & ~req.en;
      rsp.slverr <= 1'b0;
      rsp.rdata  <= 32'h0000_0000;
      if (req.sel && !req.en) begin
        if (req.addr == ADDR_INIT_CTRL)
          rsp.rdata <= {30'h0, slp_rq_q, init_rq_q};
        else if (req.addr == ADDR_STATUS)
          rsp.rdata <= {27'h0, blocked, busoff_i, sync_q, slp_ak, init_ak};
        else if (req.addr == ADDR_TBSEL)
          rsp.rdata <= {29'h0, lowest};
        else if (req.addr == ADDR_TFLG)
          rsp.rdata <= {29'h0, tflg_q};
        else if (req.addr == ADDR_TXWIN) begin
          if (blocked) rsp.slverr <= 1'b1;
          else rsp.rdata <= win_q[idx];
        end else if (req.addr == ADDR_TXSCHED)
          rsp.rdata <= {29'h0, sched_q};
        else
          rsp.slverr <= 1'b1;
      end
    end
  end
  // window write refusal also flagged
  logic werr;
  assign werr = req.wr && (req.addr == ADDR_TXWIN || req.addr == ADDR_TXSCHED)
                && blocked;
  assign pready_o  = rsp.ready;
  assign pslverr_o = rsp.ready & (rsp.slverr | werr);
  assign prdata_o  = rsp.rdata;
endmodule : cts_top

// >>> cts_top_assertions.sv
// checker of cts_top port behaviour
// assumes one clock domain, bound into every cts_top
module cts_chk
  import cts_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 25
) (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        bus_rx_i,
  input wire logic        bus_transmit_pin_o,
  input wire logic        bus_synced_o,
  input wire logic        pending_run_o,
  input wire logic [2:0]  fg_txbuf_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_acc; psel_i && penable_i && pready_o; endsequence
  a_ready_next: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_pin_recessive: assert property (bus_transmit_pin_o)
    else $error("transmit pin dominant");
  a_fg_onehot: assert property ($onehot0(fg_txbuf_o))
    else $error("window maps several buffers");
  a_sel_lowest: assert property (s_acc ##0 (!pwrite_i &&
    paddr_i == ADDR_TBSEL) |-> prdata_o == {29'h0, fg_txbuf_o})
    else $error("select read not lowest bit");
  a_win_none: assert property (s_acc ##0 (paddr_i == ADDR_TXWIN &&
    fg_txbuf_o == 3'h0) |-> pslverr_o && prdata_o == 32'h0)
    else $error("window open with no buffer");
  a_init_sync: assert property (s_acc ##0 (pwrite_i &&
    paddr_i == ADDR_INIT_CTRL && pwdata_i[0]) |-> ##[1:3] !bus_synced_o)
    else $error("sync kept in init");
  a_sync_idle: assert property ($rose(bus_synced_o) |->
    $past(bus_rx_i, 3)) else $error("synced on dominant bus");
  a_run_pulse: assert property (pending_run_o |=> !pending_run_o)
    else $error("pending run not a pulse");
endmodule : cts_chk
bind cts_top cts_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.*);

// >>> cts_top_tb.sv
// testbench of cts_top: apb traffic, select, window, sleep and init
// assumes cts_pkg, cts_node and the checker compiled before it
module cts_top_tb
  import cts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, srst_i = 1, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, frame = 0, busoff_i = 0, bus_rx_i;
  logic [7:0] paddr_i = 8'h00, lf = 8'h28;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [2:0] tx_done_i = 3'h0, fg_txbuf_o;
  logic pready_o, pslverr_o, bus_transmit_pin_o, bus_synced_o;
  logic pending_run_o, er;
  int num_errors = 0, comparisons = 0;
  cts_top #(.BIT_CYCLES(2)) u_dut (.*);
  cts_node u_node (.clk_i(clk_sys_i), .frame_i(frame), .rx_o(bus_rx_i));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task automatic complete_run;
    $display("errors %0d of %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i) penable_i <= 1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    chk(n < 50, 1);
    if (n >= 50) complete_run();
    @(posedge clk_sys_i);
  endtask : xfer
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(0, ADDR_STATUS, 0);
      n++;
    end while (rd[b] !== v && n < 100);
    chk(rd[b], v);
    if (n >= 100) complete_run();
  endtask : wait_st
  function automatic logic [2:0] low(input logic [2:0] v);
    return v & (~v + 3'h1);
  endfunction : low
  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 0;
    xfer(1, ADDR_TBSEL, 32'h7);
    xfer(0, ADDR_TBSEL, 0);
    chk(rd, 0);
    frame <= 1;
    xfer(1, ADDR_INIT_CTRL, 0);
    repeat (60) @(posedge clk_sys_i);
    xfer(0, ADDR_STATUS, 0);
    chk(rd[ST_SYNC_BIT], 0);
    frame <= 0;
    wait_st(ST_SYNC_BIT, 1);
    xfer(0, ADDR_TFLG, 0);
    xfer(1, ADDR_TBSEL, rd);
    xfer(0, ADDR_TBSEL, 0);
    chk(rd, 1);
    repeat (12) begin
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      xfer(1, ADDR_TBSEL, {4{lf}});
      xfer(0, ADDR_TBSEL, 0);
      chk(rd, low(lf[2:0]));
      chk(fg_txbuf_o, low(lf[2:0]));
    end
    xfer(1, ADDR_TBSEL, 0);
    xfer(0, ADDR_TXWIN, 0);
    chk(er, 1);
    chk(rd, 0);
    xfer(1, ADDR_TBSEL, 32'h5);
    xfer(1, ADDR_TXWIN, 32'hA5C3_5A3C);
    xfer(1, ADDR_TXSCHED, 0);
    xfer(0, ADDR_TXWIN, 0);
    chk(er, 1);
    tx_done_i <= 3'h1;
    @(posedge clk_sys_i) tx_done_i <= 3'h0;
    xfer(0, ADDR_TXWIN, 0);
    chk(er, 0);
    chk(rd, 32'hA5C3_5A3C);
    xfer(1, ADDR_INIT_CTRL, 32'h2);
    wait_st(ST_SLEEP_ACKNOWLEDGE_BIT, 1);
    xfer(1, ADDR_INIT_CTRL, 0);
    wait_st(ST_SLEEP_ACKNOWLEDGE_BIT, 0);
    xfer(1, ADDR_INIT_CTRL, 32'h1);
    chk(bus_transmit_pin_o, 1);
    wait_st(ST_INIT_ACKNOWLEDGE_BIT, 1);
    chk(rd[ST_SYNC_BIT], 0);
    xfer(0, ADDR_TBSEL, 0);
    chk(rd, 0);
    // sleep request set in init mode, clear refused while not asleep
    xfer(1, ADDR_INIT_CTRL, 32'h3);
    xfer(1, ADDR_INIT_CTRL, 32'h1);
    xfer(0, ADDR_INIT_CTRL, 0);
    chk(rd, 3);
    complete_run();
  end
endmodule : cts_top_tb
